// ### dv/ufc_asserts.sv
`default_nettype none
module ufc_asserts (
    // Watched ports
    input wire logic        clk, rst_n, cmd_write, cmd_read, cmd_rvalid, cmd_hit,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata, cmd_rdata,
    input wire logic [9:0]  min_duty_num,
    input wire logic        min_duty_active, diode_emulation_mode_refresh_en, fault_bus_en,
    input wire logic        external_temp_sensor_en, tracking_input_en,
    input wire logic        power_good_output_push_pull, temp_fault_use_external,
    input wire logic        sync_use_external, sync_drive_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Accepted requests
    wire logic wr_take = cmd_write && cmd_code == 8'hd1;
    wire logic rd_take = cmd_read && cmd_code == 8'hd1;
    property p_hit; wr_take || rd_take |=> cmd_hit; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_rv; rd_take |=> cmd_rvalid && !cmd_rdata[8] && !cmd_rdata[2]; endproperty
    a_rv: assert property (p_rv) else $error("bad read");
    property p_num;
        wr_take |-> ##3 min_duty_num == {4'h0, $past(cmd_wdata[15:11], 3), 1'b0} + 10'h002;
    endproperty
    a_num: assert property (p_num) else $error("bad min duty");
    property p_en;
        wr_take |-> ##3 {min_duty_active, diode_emulation_mode_refresh_en, fault_bus_en}
            == {$past(cmd_wdata[10:9], 3), $past(cmd_wdata[7], 3)};
    endproperty
    a_en: assert property (p_en) else $error("bad enables");
    property p_pin;
        wr_take |-> ##3 {tracking_input_en, power_good_output_push_pull}
            == {!$past(cmd_wdata[6], 3), $past(cmd_wdata[5], 3)};
    endproperty
    a_pin: assert property (p_pin) else $error("bad pin mode");
    property p_sync;
        wr_take && cmd_wdata[1:0] == 2'h1 |-> ##3 sync_drive_out && !sync_use_external;
    endproperty
    a_sync: assert property (p_sync) else $error("bad sync");
    property p_tfs; temp_fault_use_external |-> external_temp_sensor_en; endproperty
    a_tfs: assert property (p_tfs) else $error("bad fault source");
    property p_rst;
        $past(rst_n) && !$past(rst_n, 2) |-> min_duty_num == 10'h006 && min_duty_active;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
endmodule
bind ufc_user_feature_config_register ufc_asserts u_asserts (.*);
`default_nettype wire

// ### dv/ufc_host_model.sv
`default_nettype none
module ufc_host_model #(
    parameter logic [7:0] STORE_CMD = 8'h15 // Arbitrary save code
) (
    // Clock and read data
    input  wire logic        clk,
    input  wire logic [15:0] cmd_rdata,
    // Command strobes
    output logic      [7:0]  cmd_code,
    output logic             cmd_write,
    output logic             cmd_read,
    output logic      [15:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_code = 8'h2e;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_wdata = 16'h0000;
    end
    // One strobe cycle, whole word, code and data flipped when idle
    task automatic op(input logic [7:0] c, input logic w, input logic [15:0] d);
        @(negedge clk);
        {cmd_code, cmd_write, cmd_read, cmd_wdata} = {c, w, !w, d};
        @(negedge clk);
        {cmd_code, cmd_write, cmd_read, cmd_wdata} = {~c, 2'b00, ~d};
    endtask
    // Each write is saved at once
    task automatic wr(input logic [15:0] d);
        op(8'hd1, 1'b1, d);
        op(STORE_CMD, 1'b1, d);
    endtask
    task automatic rd(output logic [15:0] d);
        op(8'hd1, 1'b0, 16'h0000);
        d = cmd_rdata;
    endtask
endmodule
`default_nettype wire

// ### dv/ufc_user_feature_config_register_tb.sv
`default_nettype none
module ufc_user_feature_config_register_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, cmd_write, cmd_read, cmd_rvalid, cmd_hit, min_duty_active, fault_bus_en;
    logic diode_emulation_mode_refresh_en, external_temp_sensor_en, tracking_input_en;
    logic power_good_output_push_pull, temp_fault_use_external, temp_fault_src_invalid;
    logic sync_use_external, sync_drive_out, sync_mode_invalid;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rv;
    logic [9:0] min_duty_num;
    int errors, checks_done;
    ufc_user_feature_config_register dut (.clk, .rst_n, .cmd_code, .cmd_write, .cmd_read,
        .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_hit, .min_duty_num, .min_duty_active,
        .diode_emulation_mode_refresh_en, .fault_bus_en, .external_temp_sensor_en,
        .tracking_input_en, .power_good_output_push_pull, .temp_fault_use_external,
        .temp_fault_src_invalid, .sync_use_external, .sync_drive_out, .sync_mode_invalid);
    ufc_host_model host (.clk, .cmd_rdata, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Decoded outputs against a stored word
    task automatic chk_out(input logic [15:0] v);
        logic ext;
        ext = v[4:3] == 2'h1 && v[6];
        chk(16'(min_duty_num), {5'h00, v[15:11], 1'b0} + 16'h0002);
        chk({min_duty_active, diode_emulation_mode_refresh_en, fault_bus_en},
            {v[10:9], v[7]});
        chk({external_temp_sensor_en, tracking_input_en, power_good_output_push_pull},
            {v[6], !v[6], v[5]});
        chk({temp_fault_use_external, temp_fault_src_invalid},
            {ext, v[4:3] != 2'h0 && !ext});
        chk({sync_use_external, sync_drive_out, sync_mode_invalid},
            {v[1:0] == 2'h2, v[1:0] == 2'h1, v[1:0] == 2'h3});
    endtask
    task automatic test_reset;
        host.rd(rv);
        chk(rv, 16'h1440);
        chk(16'(cmd_rvalid), 16'h0001);
        chk_out(16'h1440);
        $display("test_reset done");
    endtask
    // Every field code, save command refused, unused bits dropped
    task automatic test_fields;
        logic [15:0] tbl [5] = '{16'hffff, 16'h0000, 16'hacc9, 16'h5352, 16'h0008};
        foreach (tbl[i]) begin
            host.wr(tbl[i]);
            chk(16'(cmd_hit), 16'h0000);
            chk_out(tbl[i]);
            host.rd(rv);
            chk(rv, tbl[i] & 16'hfefb);
        end
        $display("test_fields done");
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_fields();
        wrap_up();
    end
    // Watchdog
    initial begin
        #20us;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire

// ### rtl/ufc_pkg.sv
`default_nettype none
package ufc_pkg;
    // Command code and register layout
    localparam logic [7:0]  CMD_USER_FEATURE_CONFIG = 8'hd1;
    localparam logic [15:0] RESET_VALUE             = 16'h1440;
    localparam logic [15:0] WRITABLE_MASK           = 16'hfefb;
    localparam int          MIN_DUTY_HI             = 15;
    localparam int          MIN_DUTY_LO             = 11;
    localparam int          MIN_DUTY_EN_BIT         = 10;
    localparam int          BOOT_REFRESH_BIT        = 9;
    localparam int          FAULT_BUS_BIT           = 7;
    localparam int          TEMP_TRACK_SEL_BIT      = 6;
    localparam int          PG_PUSH_PULL_BIT        = 5;
    localparam int          TEMP_FAULT_HI           = 4;
    localparam int          TEMP_FAULT_LO           = 3;
    localparam int          SYNC_HI                 = 1;
    localparam int          SYNC_LO                 = 0;
    localparam int          DATA_BYTES              = 2;
    // Temperature fault source codes
    localparam logic [1:0]  TFS_INTERNAL            = 2'h0;
    localparam logic [1:0]  TFS_EXTERNAL            = 2'h1;
    // Sync pin modes
    localparam logic [1:0]  SYNC_INTERNAL           = 2'h0;
    localparam logic [1:0]  SYNC_INTERNAL_OUT       = 2'h1;
    localparam logic [1:0]  SYNC_EXTERNAL           = 2'h2;
    // Minimum duty numerator: duty = MIN_DUTY_NUM / 512 percent
    localparam int          MIN_DUTY_DIV            = 512;
endpackage
`default_nettype wire

// ### rtl/ufc_store.sv
`default_nettype none
module ufc_store #(
    parameter int                WIDTH = 16,
    parameter logic [WIDTH-1:0]  RST   = '0,
    parameter logic [WIDTH-1:0]  MASK  = '1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Write side
    input  wire logic             we,
    input  wire logic [WIDTH-1:0] wdata,
    // Stored value
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // Masked load; bits outside the mask stay zero
    always_comb begin
        q_nxt = q_r;
        if (we) begin
            q_nxt = wdata & MASK;
        end
    end

    // Register with synchronous reset to default
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ### rtl/ufc_user_feature_config_register.sv
// Summary of operation
// - Bits 15:11 set minimum duty, (n+1)*2/512 percent
// - Bit 10 enables the minimum duty limit
// - Bit 9 enables boot refresh pulse in diode emulation
// - Reset value is 1440h
// - Bit 6 picks external sensor or tracking input
// - Bit 5 picks push-pull or open-drain power good
// - Bits 4:3 pick temperature fault source
// - Bits 1:0 pick sync pin clock mode
// - Two-byte value, readable and writable
`default_nettype none
module ufc_user_feature_config_register (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Command port from the bus engine
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_rvalid,
    output logic             cmd_hit,
    // Minimum duty
    output logic      [9:0]  min_duty_num,
    output logic             min_duty_active,
    // Diode emulation boot refresh
    output logic             diode_emulation_mode_refresh_en,
    // Fault bus
    output logic             fault_bus_en,
    // Shared temperature/tracking pin
    output logic             external_temp_sensor_en,
    output logic             tracking_input_en,
    // Power good drive style
    output logic             power_good_output_push_pull,
    // Temperature fault source
    output logic             temp_fault_use_external,
    output logic             temp_fault_src_invalid,
    // Sync pin
    output logic             sync_use_external,
    output logic             sync_drive_out,
    output logic             sync_mode_invalid
);
    // Block overview
    // This block holds one 16-bit user configuration word and fans it out
    // as ready-decoded control levels to the modulator, the fault logic,
    // the shared temperature/tracking pin and the sync circuitry.
    // The bus engine outside has already assembled the two data bytes
    // into one word, so every access here is a single-cycle strobe.
    //
    // Command port
    // A write or read strobe counts only when cmd_code names this word.
    // Any other code is left for the neighbouring command handlers and
    // produces no hit, no read answer and no change of state.
    // Write and read may come back to back with no idle cycle between.
    // A read in the same cycle as a write returns the old value, because
    // the read answer is taken from the stored word before the load.
    //
    // Timing of a write
    // Edge 0: strobe sampled, stored word loaded, cmd_hit set.
    // Edge 1: decoded outputs registered from the new stored word.
    // So a consumer sees the new setting two edges after the strobe.
    //
    // Timing of a read
    // Edge 0: strobe sampled, cmd_rdata loaded, cmd_rvalid and cmd_hit set.
    // cmd_rvalid and cmd_hit stand for one cycle only.
    // cmd_rdata stands until the next read of this word, so a slow
    // engine may pick it up late without a second request.
    //
    // Stored bits
    // Bits 8 and 2 have no function. They are cleared by the write mask,
    // so they always read back as zero whatever the host writes there,
    // and nothing downstream can ever react to them.
    //
    // Minimum duty
    // Bits 15:11 hold a setting of 0 to 31. The duty floor is
    // 2*(setting+1)/512 percent; this block hands out only the numerator
    // over 512, from 2 up to 64, and the modulator does the scaling.
    // The floor applies only while min_duty_active is high.
    //
    // Boot refresh
    // While diode_emulation_mode_refresh_en is high, the modulator adds a
    // minimum low-side pulse in every switching cycle during diode
    // emulation, so the high-side bootstrap capacitor never runs flat.
    //
    // Shared temperature/tracking pin
    // Exactly one of external_temp_sensor_en and tracking_input_en is
    // high at any time outside reset; the pin can never serve both.
    //
    // Temperature fault source
    // Code 00 picks the internal sensor and 01 the external one.
    // The external source is only honoured while the external sensor is
    // enabled; otherwise the code is flagged invalid and the fault logic
    // keeps using the internal sensor. Codes 10 and 11 are flagged too.
    //
    // Sync pin
    // 00 runs from the internal clock, 01 also drives that clock out on
    // the pin, 10 follows an external clock and 11 is flagged invalid.
    // Mode 01 must not be combined with a pin-strap on the sync pin; the
    // block cannot see the strap, so this stays a user responsibility.
    //
    // Reset
    // Reset is synchronous and active low. The stored word returns to
    // its default while the decoded outputs are held at zero; the first
    // edge after release registers the decode of the default word.
    // Holding the outputs at zero in reset keeps the pin drivers and the
    // sync output quiet until the configuration is known.
    //
    // Saving the word
    // Copying the word to non-volatile store is the host's job right
    // after each write; this block has no store path of its own.

    // Stored word and command select
    logic [15:0] cfg;
    logic        sel;
    // Read answer registers
    logic [15:0] cmd_rdata_r;
    logic [15:0] cmd_rdata_nxt;
    logic        cmd_rvalid_r;
    logic        cmd_rvalid_nxt;
    logic        cmd_hit_r;
    logic        cmd_hit_nxt;
    // Decoded field registers
    logic [9:0]  min_duty_num_r;
    logic [9:0]  min_duty_num_nxt;
    logic [10:0] dec_r;
    logic [10:0] dec_nxt;
    // Field slices of the stored word
    logic [1:0]  tfs;
    logic [1:0]  sync_mode;

    assign sel = (cmd_code == ufc_pkg::CMD_USER_FEATURE_CONFIG);

    // Configuration storage; unused bits masked off
    ufc_store #(
        .WIDTH (16),
        .RST   (ufc_pkg::RESET_VALUE),
        .MASK  (ufc_pkg::WRITABLE_MASK)
    ) u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (cmd_write && sel),
        .wdata (cmd_wdata),
        .q     (cfg)
    );

    assign tfs       = cfg[ufc_pkg::TEMP_FAULT_HI:ufc_pkg::TEMP_FAULT_LO];
    assign sync_mode = cfg[ufc_pkg::SYNC_HI:ufc_pkg::SYNC_LO];

    // Read answer and decoded field outputs
    always_comb begin
        cmd_rvalid_nxt = cmd_read && sel;
        cmd_hit_nxt    = (cmd_read || cmd_write) && sel;
        cmd_rdata_nxt  = cmd_rdata_r;
        if (cmd_read && sel) begin
            cmd_rdata_nxt = cfg;
        end
        // Duty numerator over 512: 2*(setting+1)
        min_duty_num_nxt = {4'h0,
            (6'({1'b0, cfg[ufc_pkg::MIN_DUTY_HI:ufc_pkg::MIN_DUTY_LO]}) + 6'h01)} << 1;
        dec_nxt[0]  = cfg[ufc_pkg::MIN_DUTY_EN_BIT];
        dec_nxt[1]  = cfg[ufc_pkg::BOOT_REFRESH_BIT];
        dec_nxt[2]  = cfg[ufc_pkg::FAULT_BUS_BIT];
        dec_nxt[3]  = cfg[ufc_pkg::TEMP_TRACK_SEL_BIT];
        dec_nxt[4]  = !cfg[ufc_pkg::TEMP_TRACK_SEL_BIT];
        dec_nxt[5]  = cfg[ufc_pkg::PG_PUSH_PULL_BIT];
        // External fault source only counts if the sensor is enabled
        dec_nxt[6]  = (tfs == ufc_pkg::TFS_EXTERNAL) &&
                      cfg[ufc_pkg::TEMP_TRACK_SEL_BIT];
        dec_nxt[7]  = (tfs != ufc_pkg::TFS_INTERNAL) &&
                      !dec_nxt[6];
        dec_nxt[8]  = (sync_mode == ufc_pkg::SYNC_EXTERNAL);
        dec_nxt[9]  = (sync_mode == ufc_pkg::SYNC_INTERNAL_OUT);
        dec_nxt[10] = (sync_mode == 2'h3);
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_rdata_r    <= 16'h0000;
            cmd_rvalid_r   <= 1'b0;
            cmd_hit_r      <= 1'b0;
            min_duty_num_r <= 10'h000;
            dec_r          <= 11'h000;
        end else begin
            cmd_rdata_r    <= cmd_rdata_nxt;
            cmd_rvalid_r   <= cmd_rvalid_nxt;
            cmd_hit_r      <= cmd_hit_nxt;
            min_duty_num_r <= min_duty_num_nxt;
            dec_r          <= dec_nxt;
        end
    end

    assign cmd_rdata                       = cmd_rdata_r;
    assign cmd_rvalid                      = cmd_rvalid_r;
    assign cmd_hit                         = cmd_hit_r;
    assign min_duty_num                    = min_duty_num_r;
    assign min_duty_active                 = dec_r[0];
    assign diode_emulation_mode_refresh_en = dec_r[1];
    assign fault_bus_en                    = dec_r[2];
    assign external_temp_sensor_en         = dec_r[3];
    assign tracking_input_en               = dec_r[4];
    assign power_good_output_push_pull     = dec_r[5];
    assign temp_fault_use_external         = dec_r[6];
    assign temp_fault_src_invalid          = dec_r[7];
    assign sync_use_external               = dec_r[8];
    assign sync_drive_out                  = dec_r[9];
    assign sync_mode_invalid               = dec_r[10];
endmodule
`default_nettype wire
